// File: src/arpm_top.sv
// How it works
// - External clock mode: internal ADC reference powers down when a scan finishes.
// - Reference was off before a conversion: wait 218 conversion clocks first.
// - Temperature reading powers the internal reference and waits 244 conversion clocks.
// - Temperature result is ready 188 further conversion clocks after settling.
// - Reference select 10 is default: ADC internal, DAC on external pin.
// - Pair select 00 or 01: no data byte, pair registers unchanged.
// - Pair select 10: next byte written to the unipolar pair register.
// - Pair select 11: next byte written to the bipolar pair register.
// - Unipolar bits 7..4 make pairs 0/1..6/7 unipolar differential; low bits ignored.
// - Bipolar bits 7..4 make pairs 0/1..6/7 bipolar differential unless the unipolar bit is also set; low bits ignored.
// - Pair with both bits clear converts as two single-ended unipolar channels.
// - Clock select 11 uses the serial clock as the conversion clock.
// - Command byte with top bits 01 is setup; low two bits are pair select.
// - Both pair registers reset to zero: eight single-ended unipolar inputs.
`timescale 1ns/10ps
module arpm_top
  import arpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic ain_conv_req,
  input wire logic temp_req,
  input wire logic scan_done,
  output logic ref_power_on,
  output logic adc_conv_go,
  output logic temp_result_ready,
  output logic conv_busy,
  output logic adc_ref_internal,
  output logic dac_ref_external_pin,
  output logic conv_clock_external,
  output logic [1:0] clock_select,
  output logic [7:0] pair_mode_code
);

  // ---------------------------------------------------------------
  // Pin synchronisers and serial byte framing
  // ---------------------------------------------------------------
  logic cs_sel_lvl, sclk_lvl, din_lvl;
  logic sclk_prev_q, cs_prev_q;
  logic sclk_rise, cs_rise;
  logic byte_valid;
  logic [7:0] byte_data;

  arpm_sync u_sync_cs (.ref_clk(ref_clk), .rst(rst), .pin(!cs_n), .level(cs_sel_lvl));
  arpm_sync u_sync_sclk (.ref_clk(ref_clk), .rst(rst), .pin(sclk), .level(sclk_lvl));
  arpm_sync u_sync_din (.ref_clk(ref_clk), .rst(rst), .pin(din), .level(din_lvl));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_lvl;
      cs_prev_q <= !cs_sel_lvl;
    end
  end

  assign sclk_rise = sclk_lvl && !sclk_prev_q;
  assign cs_rise = !cs_sel_lvl && !cs_prev_q;

  arpm_serial_rx u_rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .cs_n_lvl(!cs_sel_lvl),
    .sclk_rise(sclk_rise),
    .din_lvl(din_lvl),
    .byte_valid(byte_valid),
    .byte_data(byte_data)
  );

  // ---------------------------------------------------------------
  // Setup command decode and pair registers
  // ---------------------------------------------------------------
  logic [1:0] clksel_q, clksel_d, refsel_q, refsel_d;
  logic [3:0] uni_q, uni_d, bi_q, bi_d;
  logic pend_q, pend_d, pend_bi_q, pend_bi_d;
  logic is_setup;

  assign is_setup = byte_data[CMD_TAG_LSB +: 2] == CMD_TAG_SETUP;

  always_comb begin
    clksel_d = clksel_q;
    refsel_d = refsel_q;
    uni_d = uni_q;
    bi_d = bi_q;
    pend_d = pend_q;
    pend_bi_d = pend_bi_q;
    if (byte_valid) begin
      if (pend_q) begin
        // Only the upper nibble is kept; the low bits carry nothing.
        if (pend_bi_q) begin
          bi_d = byte_data[PAIR_FIELD_LSB +: PAIR_COUNT];
        end else begin
          uni_d = byte_data[PAIR_FIELD_LSB +: PAIR_COUNT];
        end
        pend_d = 1'b0;
      end else if (is_setup) begin
        clksel_d = byte_data[CLKSEL_LSB +: 2];
        refsel_d = byte_data[REFSEL_LSB +: 2];
        pend_d = byte_data[PAIRSEL_WRITE_BIT];
        pend_bi_d = byte_data[PAIRSEL_TARGET_BIT];
      end
    end
    // An unfinished data byte is lost when the frame closes.
    if (cs_rise) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clksel_q <= CLKSEL_RESET;
      refsel_q <= REFSEL_RESET;
      uni_q <= PAIR_REG_RESET;
      bi_q <= PAIR_REG_RESET;
      pend_q <= 1'b0;
      pend_bi_q <= 1'b0;
    end else begin
      clksel_q <= clksel_d;
      refsel_q <= refsel_d;
      uni_q <= uni_d;
      bi_q <= bi_d;
      pend_q <= pend_d;
      pend_bi_q <= pend_bi_d;
    end
  end

  // ---------------------------------------------------------------
  // Pair mode and reference routing outputs
  // ---------------------------------------------------------------
  logic [7:0] pair_code_q, pair_code_d;
  logic adc_int_q, adc_int_d, dac_ext_q, dac_ext_d;

  for (genvar p = 0; p < PAIR_COUNT; p++) begin : g_pair
    // Bit 3 of each register is pair 0/1, bit 0 is pair 6/7.
    assign pair_code_d[2*p +: 2] = arpm_pair_code(uni_d[3-p], bi_d[3-p]);
  end

  always_comb begin
    adc_int_d = (refsel_d == REFSEL_INT_BOTH) || (refsel_d == REFSEL_INT_ADC);
    dac_ext_d = refsel_d != REFSEL_INT_BOTH;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pair_code_q <= 8'h00;
      adc_int_q <= 1'b1;
      dac_ext_q <= 1'b1;
    end else begin
      pair_code_q <= pair_code_d;
      adc_int_q <= adc_int_d;
      dac_ext_q <= dac_ext_d;
    end
  end

  assign pair_mode_code = pair_code_q;
  assign adc_ref_internal = adc_int_q;
  assign dac_ref_external_pin = dac_ext_q;
  assign clock_select = clksel_q;
  assign conv_clock_external = clksel_q == CLKSEL_EXTERNAL;

  // ---------------------------------------------------------------
  // Reference power sequencing
  // ---------------------------------------------------------------
  // With the external clock the delays only advance while the host
  // toggles the serial clock; a host that stops clocking stalls them.
  arpm_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic ref_on_q, ref_on_d, go_q, go_d, tready_q, tready_d;
  logic tick;

  assign tick = conv_clock_external ? sclk_rise : 1'b1;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ref_on_d = ref_on_q;
    go_d = 1'b0;
    tready_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (temp_req) begin
          ref_on_d = 1'b1;
          cnt_d = TEMP_SETTLE_CYCLES - 8'h01;
          state_d = ST_TSETTLE;
        end else if (ain_conv_req) begin
          if (adc_int_q && !ref_on_q) begin
            ref_on_d = 1'b1;
            cnt_d = WAKE_CYCLES - 8'h01;
            state_d = ST_WAKE;
          end else begin
            go_d = 1'b1;
            state_d = ST_SCAN;
          end
        end
      end
      ST_WAKE: begin
        if (tick) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            go_d = 1'b1;
            state_d = ST_SCAN;
          end
        end
      end
      ST_SCAN: begin
        if (scan_done) begin
          if (adc_int_q) begin
            ref_on_d = 1'b0;
          end
          state_d = ST_IDLE;
        end
      end
      ST_TSETTLE: begin
        if (tick) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            cnt_d = TEMP_OUT_CYCLES - 8'h01;
            state_d = ST_TOUT;
          end
        end
      end
      ST_TOUT: begin
        if (tick) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            tready_d = 1'b1;
            // The reference stays up only if the ADC also relies on it.
            ref_on_d = adc_int_q;
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      ref_on_q <= 1'b0;
      go_q <= 1'b0;
      tready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ref_on_q <= ref_on_d;
      go_q <= go_d;
      tready_q <= tready_d;
    end
  end

  assign ref_power_on = ref_on_q;
  assign adc_conv_go = go_q;
  assign temp_result_ready = tready_q;
  assign conv_busy = state_q != ST_IDLE;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Independent count of ticks spent in the current state.
  logic [7:0] ph_q;

  always_ff @(posedge ref_clk) begin
    if (rst || state_d != state_q) begin
      ph_q <= 8'h00;
    end else if (tick) begin
      ph_q <= ph_q + 8'h01;
    end
  end

  AST_REF_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_SCAN && scan_done && adc_int_q |=> !ref_power_on && !conv_busy)
    else $error("reference not powered down after scan");

  AST_WAKE_LEN: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_WAKE && state_d == ST_SCAN |-> tick && ph_q == 8'hd9 ##1 adc_conv_go)
    else $error("wake-up delay is not 218 cycles");

  AST_TEMP_SETTLE: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_TSETTLE && state_d == ST_TOUT |-> tick && ph_q == 8'hf3 && ref_on_q)
    else $error("temperature settling is not 244 cycles");

  AST_TEMP_OUT: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_TOUT && state_d == ST_IDLE |-> tick && ph_q == 8'hbb ##1 temp_result_ready)
    else $error("temperature result not after 188 cycles");

  AST_TEMP_START: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_IDLE && temp_req |=> ref_power_on && state_q == ST_TSETTLE [*2])
    else $error("temperature request did not power reference");

  AST_REF_DEFAULT: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> refsel_q == REFSEL_INT_ADC && adc_ref_internal && dac_ref_external_pin)
    else $error("reference mode not default after reset");

  AST_NO_DATA: assert property (@(posedge ref_clk) disable iff (rst)
    byte_valid && !pend_q && is_setup && !byte_data[PAIRSEL_WRITE_BIT]
    |=> !pend_q && $stable(uni_q) && $stable(bi_q))
    else $error("pair select 0x changed a pair register");

  AST_UNI_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    byte_valid && pend_q && !pend_bi_q
    |=> uni_q == $past(byte_data[7:4]) && $stable(bi_q) && pair_mode_code[1] == $past(byte_data[7]))
    else $error("unipolar pair register not written");

  AST_BI_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    byte_valid && pend_q && pend_bi_q |=> bi_q == $past(byte_data[7:4]) && $stable(uni_q))
    else $error("bipolar pair register not written");

  AST_SE_PAIR: assert property (@(posedge ref_clk) disable iff (rst)
    !uni_q[3] && !bi_q[3] ##1 $stable(uni_q) && $stable(bi_q)
    |-> pair_mode_code[1:0] == PAIR_SE_UNIPOLAR)
    else $error("pair 0/1 not single-ended with both bits clear");

  AST_ABORT: assert property (@(posedge ref_clk) disable iff (rst)
    cs_rise && !byte_valid |=> !pend_q ##1 $stable(uni_q) && $stable(bi_q))
    else $error("partial pair byte not discarded");

  AST_EXT_TICK: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_WAKE && conv_clock_external && !sclk_rise |=> cnt_q == $past(cnt_q))
    else $error("delay advanced without serial clock edge");

  COV_WAKE: cover property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_WAKE ##1 state_q == ST_SCAN);
  COV_TEMP: cover property (@(posedge ref_clk) disable iff (rst) temp_result_ready);
  COV_UNI: cover property (@(posedge ref_clk) disable iff (rst)
    byte_valid && pend_q && !pend_bi_q);
  COV_BI: cover property (@(posedge ref_clk) disable iff (rst)
    byte_valid && pend_q && pend_bi_q);

endmodule // arpm_top

// File: pkg/arpm_pkg.sv
package arpm_pkg;

  // ---------------------------------------------------------------
  // Command byte layout
  // ---------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int CMD_TAG_LSB = 6;
  localparam int CLKSEL_LSB = 4;
  localparam int REFSEL_LSB = 2;
  localparam int PAIRSEL_WRITE_BIT = 1;
  localparam int PAIRSEL_TARGET_BIT = 0;
  localparam int PAIR_FIELD_LSB = 4;
  localparam int PAIR_COUNT = 4;
  localparam logic [1:0] CMD_TAG_SETUP = 2'h1;

  // ---------------------------------------------------------------
  // Modes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] CLKSEL_EXTERNAL = 2'h3;
  localparam logic [1:0] CLKSEL_RESET = 2'h2;
  localparam logic [1:0] REFSEL_INT_BOTH = 2'h0;
  localparam logic [1:0] REFSEL_EXT_SINGLE = 2'h1;
  localparam logic [1:0] REFSEL_INT_ADC = 2'h2;
  localparam logic [1:0] REFSEL_EXT_DIFF = 2'h3;
  localparam logic [1:0] REFSEL_RESET = REFSEL_INT_ADC;
  localparam logic [3:0] PAIR_REG_RESET = 4'h0;
  localparam logic [1:0] PAIR_SE_UNIPOLAR = 2'h0;
  localparam logic [1:0] PAIR_DIFF_BIPOLAR = 2'h1;
  localparam logic [1:0] PAIR_DIFF_UNIPOLAR = 2'h2;

  // ---------------------------------------------------------------
  // Delays in conversion clock cycles
  // ---------------------------------------------------------------
  localparam logic [7:0] WAKE_CYCLES = 8'hda;
  localparam logic [7:0] TEMP_SETTLE_CYCLES = 8'hf4;
  localparam logic [7:0] TEMP_OUT_CYCLES = 8'hbc;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_SCAN = 3'b010,
    ST_TSETTLE = 3'b011,
    ST_TOUT = 3'b100
  } arpm_state_t;

  // Unipolar bit wins over bipolar bit; both clear means single-ended.
  function automatic logic [1:0] arpm_pair_code(input logic uni, input logic bi);
    if (uni) begin
      return PAIR_DIFF_UNIPOLAR;
    end else if (bi) begin
      return PAIR_DIFF_BIPOLAR;
    end
    return PAIR_SE_UNIPOLAR;
  endfunction

endpackage

// File: src/arpm_sync.sv
`timescale 1ns/10ps
module arpm_sync
  import arpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  logic s1_q, s2_q, s3_q, level_q;
  logic level_d;

  // A change is accepted only once the second and third stages agree.
  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule // arpm_sync

// File: src/arpm_serial_rx.sv
`timescale 1ns/10ps
module arpm_serial_rx
  import arpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n_lvl,
  input wire logic sclk_rise,
  input wire logic din_lvl,
  output logic byte_valid,
  output logic [7:0] byte_data
);

  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d, data_q, data_d;
  logic valid_q, valid_d;

  // Deselect throws away any partial byte, so framing restarts cleanly.
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    data_d = data_q;
    valid_d = 1'b0;
    if (cs_n_lvl) begin
      bit_cnt_d = 3'h0;
    end else if (sclk_rise) begin
      shift_d = {shift_q[6:0], din_lvl};
      bit_cnt_d = bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'(BYTE_BITS - 1)) begin
        data_d = {shift_q[6:0], din_lvl};
        valid_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      data_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      data_q <= data_d;
      valid_q <= valid_d;
    end
  end

  assign byte_valid = valid_q;
  assign byte_data = data_q;

endmodule // arpm_serial_rx

// File: sim/arpm_host_model.sv
`timescale 1ns/10ps
module arpm_host_model (
  output logic cs_n,
  output logic sclk,
  output logic din
);
  // ---------------------------------------------------------------
  // Serial host: the clock rests low between frames
  // ---------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b1;
  end

  // Shifts the word MSB first; a pair write sends the full 16 bits, a setup alone sends 8,
  // and any other count is an aborted frame. After release din shows the inverse of its last bit.
  task automatic send(input logic [15:0] word, input int nbits);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      din = word[15 - i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #40 din = ~din;
    cs_n = 1'b1;
    #400;
  endtask

  // Runs n conversion clocks with zero data, which decodes as no command.
  task automatic run(input int n);
    cs_n = 1'b0;
    din = 1'b0;
    repeat (n) begin
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #40 din = 1'b1;
    cs_n = 1'b1;
    #400;
  endtask
endmodule // arpm_host_model

// File: sim/test_adc_ref_and_pair_mode_config.sv
`timescale 1ns/10ps
module test_adc_ref_and_pair_mode_config;
  logic ref_clk, rst, ain_conv_req, temp_req, scan_done;
  logic cs_n, sclk, din;
  logic ref_power_on, adc_conv_go, temp_result_ready, conv_busy;
  logic adc_ref_internal, dac_ref_external_pin, conv_clock_external;
  logic [1:0] clock_select;
  logic [7:0] pair_mode_code;
  logic [15:0] lfsr_state;
  logic [7:0] uni_exp, bi_exp, data;
  logic [1:0] sel;
  int n_fail = 0;
  int comparisons = 0;
  int n_rise = 0;
  int seen;

  arpm_top arpm_top_inst (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .din(din), .ain_conv_req(ain_conv_req), .temp_req(temp_req), .scan_done(scan_done),
    .ref_power_on(ref_power_on), .adc_conv_go(adc_conv_go),
    .temp_result_ready(temp_result_ready), .conv_busy(conv_busy),
    .adc_ref_internal(adc_ref_internal), .dac_ref_external_pin(dac_ref_external_pin),
    .conv_clock_external(conv_clock_external), .clock_select(clock_select),
    .pair_mode_code(pair_mode_code));
  arpm_host_model arpm_host_model_inst (.cs_n(cs_n), .sclk(sclk), .din(din));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge sclk) n_rise++;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Pair 0/1 sits in register bit 7 and in code bits 1:0; the unipolar bit wins.
  function automatic logic [7:0] exp_code(input logic [7:0] u, input logic [7:0] b);
    logic [7:0] c;
    for (int p = 0; p < 4; p++) begin
      c[2*p +: 2] = u[7-p] ? 2'h2 : (b[7-p] ? 2'h1 : 2'h0);
    end
    return c;
  endfunction

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_int(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic request(input int which);
    @(posedge ref_clk);
    #1;
    case (which)
      0: ain_conv_req = 1'b1;
      1: temp_req = 1'b1;
      default: scan_done = 1'b1;
    endcase
    @(posedge ref_clk);
    #1;
    ain_conv_req = 1'b0;
    temp_req = 1'b0;
    scan_done = 1'b0;
  endtask

  // Waits for a start or result pulse and reports how many serial clocks had risen.
  task automatic wait_flag(input int which, output int rises);
    rises = -1;
    repeat (60000) begin
      @(posedge ref_clk);
      #1;
      if ((which == 0 ? adc_conv_go : temp_result_ready) === 1'b1) begin
        rises = n_rise;
        return;
      end
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    $display("[FAIL] watchdog expected finish seen hang");
    close_out();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ain_conv_req = 1'b0;
    temp_req = 1'b0;
    scan_done = 1'b0;
    uni_exp = 8'h00;
    bi_exp = 8'h00;
    lfsr_state = 16'hb3ff;
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    @(posedge ref_clk);
    #1;
    check8("pair_mode_code", 8'h00, pair_mode_code);
    check8("adc_ref_internal", 8'h01, {7'h0, adc_ref_internal});
    check8("dac_ref_external_pin", 8'h01, {7'h0, dac_ref_external_pin});
    check8("clock_select", 8'h02, {6'h0, clock_select});
    check8("ref_power_on", 8'h00, {7'h0, ref_power_on});
    $display("test reset done");
    repeat (8) @(posedge ref_clk);
    #1;
    // The first four frames walk every select code, the rest are random.
    for (int i = 0; i < 24; i++) begin
      lfsr_state = lfsr_next(lfsr_state);
      sel = (i < 4) ? i[1:0] : lfsr_state[1:0];
      data = lfsr_state[15:8];
      if (sel[1]) begin
        arpm_host_model_inst.send({6'h1a, sel, data}, 16);
        if (sel[0]) bi_exp = data;
        else uni_exp = data;
      end else begin
        arpm_host_model_inst.send({6'h1a, sel, data & 8'h3f}, 16);
      end
      check8("pair_mode_code", exp_code(uni_exp, bi_exp), pair_mode_code);
    end
    arpm_host_model_inst.send({6'h1a, 2'h2, ~uni_exp}, 12);
    check8("pair_mode_code", exp_code(uni_exp, bi_exp), pair_mode_code);
    check8("clock_select", 8'h02, {6'h0, clock_select});
    $display("test pair done");
    for (int r = 0; r < 4; r++) begin
      arpm_host_model_inst.send({4'h6, r[1:0], 2'h0, 8'h00}, 8);
      check8("adc_ref_internal", {7'h0, r == 0 || r == 2}, {7'h0, adc_ref_internal});
      check8("dac_ref_external_pin", {7'h0, r != 0}, {7'h0, dac_ref_external_pin});
    end
    arpm_host_model_inst.send({8'h78, 8'h00}, 8);
    check8("conv_clock_external", 8'h01, {7'h0, conv_clock_external});
    check8("clock_select", 8'h03, {6'h0, clock_select});
    check8("pair_mode_code", exp_code(uni_exp, bi_exp), pair_mode_code);
    $display("test modes done");
    request(0);
    n_rise = 0;
    fork
      arpm_host_model_inst.run(230);
      wait_flag(0, seen);
    join
    check_int("wake ticks", 218, seen);
    check8("ref_power_on", 8'h01, {7'h0, ref_power_on});
    request(2);
    @(posedge ref_clk);
    #1;
    check8("ref_power_on", 8'h00, {7'h0, ref_power_on});
    check8("conv_busy", 8'h00, {7'h0, conv_busy});
    $display("test wake done");
    request(1);
    n_rise = 0;
    fork
      arpm_host_model_inst.run(440);
      wait_flag(1, seen);
    join
    check_int("temperature ticks", 432, seen);
    check8("conv_busy", 8'h00, {7'h0, conv_busy});
    check8("ref_power_on", 8'h01, {7'h0, ref_power_on});
    $display("test temperature done");
    // With the reference already up, a conversion starts with no wake-up delay.
    request(0);
    check8("adc_conv_go", 8'h01, {7'h0, adc_conv_go});
    request(2);
    check8("ref_power_on", 8'h00, {7'h0, ref_power_on});
    $display("test warm start done");
    close_out();
  end
endmodule // test_adc_ref_and_pair_mode_config
